/* logic/fcv_cmd_gate.sv */
// Function
// - 35h enters quad protocol, F5h leaves it, at once.
// - CRC-64 uses the ECMA generator polynomial.
// - Data consumed LSB first; CRC starts from all zeros.
// - Computed CRC compared with expected; result in flag bit 4.
// - On mismatch the computed CRC is saved in the read-back register.
// - 96h shifts the read-back register out, low byte first.
// - Read-back register cleared at the start of every CRC operation.
// - Read-back register cleared by power-up, hardware or software reset.
// - Read-back read starts at first byte; past the end gives 00h.
// - Whole check: 9Bh 27h FFh then eight expected bytes, LSB first.
// - Range check adds start and stop addresses, four bytes each.
// - Start and stop are first and last byte addresses covered.
// - CRC operation starts only when select rises after full sequence.
// - One device state at a time; permission uniform except erase suspend.
// - Array reads refused only during program/erase.
// - Status and flag status reads accepted in every state.
// - Program accepted in standby, or erase suspend outside suspended sector.
// - Sector and subsector erase accepted only in standby.
// - Status, nonvolatile config, OTP program, die erase: standby only.
// - Volatile writes, enables, flag clear, lock: not during program/erase.
// - Suspend accepted only while program or erase is running.
module fcv_cmd_gate #(
  parameter logic [31:0] ARRAY_LAST = 32'h0000ffff,
  // Opcode values below are arbitrary defaults
  parameter logic [7:0] OP_READ = 8'h03,
  parameter logic [7:0] OP_RDSR = 8'h05,
  parameter logic [7:0] OP_RDFSR = 8'h70,
  parameter logic [7:0] OP_PROG = 8'h02,
  parameter logic [7:0] OP_SECT_ERASE = 8'hd8,
  parameter logic [7:0] OP_SUB_ERASE = 8'h20,
  parameter logic [7:0] OP_WRSR = 8'h01,
  parameter logic [7:0] OP_WRNVCR = 8'hb1,
  parameter logic [7:0] OP_OTP_PROG = 8'h42,
  parameter logic [7:0] OP_DIE_ERASE = 8'hc4,
  parameter logic [7:0] OP_WRVCR = 8'h81,
  parameter logic [7:0] OP_WREVCR = 8'h61,
  parameter logic [7:0] OP_WREN = 8'h06,
  parameter logic [7:0] OP_WRDI = 8'h04,
  parameter logic [7:0] OP_CLRFS = 8'h50,
  parameter logic [7:0] OP_WRLOCK = 8'he5,
  parameter logic [7:0] OP_SUSPEND = 8'h75,
  parameter logic [7:0] OP_RESUME = 8'h7a,
  parameter logic [7:0] OP_RST_EN = 8'h66,
  parameter logic [7:0] OP_RST_MEM = 8'h99
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial link from the host
  input wire logic linkClk,
  input wire logic csN,
  input wire logic [3:0] dqIn,
  output logic [3:0] dqOut,
  output logic [3:0] dqOe,
  // Array read port
  output logic memReq,
  output logic [31:0] memAddr,
  input wire logic memValid,
  input wire logic [7:0] memData,
  // Array controller status
  input wire logic opDone,
  input wire logic suspSectorHit,
  // Gating and status
  output logic cmdAccept,
  output logic cmdReject,
  output logic [3:0] cmdClass,
  output logic [1:0] devState,
  output logic quadMode,
  output logic crcBusy,
  output logic crcFailFlag
);

  // ==========================================================
  // Parameter checks
  if (OP_SUSPEND == OP_RESUME || OP_RST_EN == OP_RST_MEM) begin : g_bad_ops
    $error("suspend/resume or reset opcodes must differ");
  end

  // ==========================================================
  // CRC-64 over one byte, LSB first
  function automatic logic [63:0] crcByte(input logic [63:0] c, input logic [7:0] d);
    logic [63:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = {r[62:0], 1'b0} ^ ((r[63] ^ d[i]) ? fcv_pkg::CRC_POLY : 64'h0);
    end
    return r;
  endfunction : crcByte

  logic [63:0] rbWord_reg, rbWord_next;
  logic quadMode_reg, crcBusy_reg;

  // ==========================================================
  // Link domain
  logic quadMeta, quadLink;
  logic [7:0] inShift_reg, inShift_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic opSeen_reg, opSeen_next;
  logic rdAct_reg, rdAct_next;
  logic [3:0] rbIdx_reg, rbIdx_next;
  logic [7:0] outShift_reg, outShift_next;
  logic byteTgl_reg, byteTgl_next;
  logic [7:0] byteHold_reg, byteHold_next;
  logic [3:0] dqOut_reg, dqOut_next, dqOe_reg, dqOe_next;
  logic [3:0] bitSum;
  logic [7:0] newByte;

  // Quad flag into the link clock
  always_ff @(posedge linkClk) begin
    quadMeta <= quadMode_reg;
    quadLink <= quadMeta;
  end

  // Byte assembly and read-back shifter
  always_comb begin
    inShift_next = inShift_reg;
    bitCnt_next = bitCnt_reg;
    opSeen_next = opSeen_reg;
    rdAct_next = rdAct_reg;
    rbIdx_next = rbIdx_reg;
    outShift_next = outShift_reg;
    byteTgl_next = byteTgl_reg;
    byteHold_next = byteHold_reg;
    bitSum = {1'b0, bitCnt_reg} + (quadLink ? 4'h4 : 4'h1);
    newByte = quadLink ? {inShift_reg[3:0], dqIn} : {inShift_reg[6:0], dqIn[0]};
    if (!rdAct_reg) begin
      inShift_next = newByte;
      bitCnt_next = bitSum[2:0];
      if (bitSum[3]) begin
        byteHold_next = newByte;
        byteTgl_next = ~byteTgl_reg;
        opSeen_next = 1'b1;
        if (!opSeen_reg && newByte == fcv_pkg::OP_RB_READ) begin
          rdAct_next = 1'b1;
          outShift_next = rbWord_reg[7:0];
          rbIdx_next = 4'h1;
        end
      end
    end else if (bitSum[3]) begin
      bitCnt_next = 3'h0;
      outShift_next = (rbIdx_reg < fcv_pkg::RB_BYTES) ?
        rbWord_reg[{rbIdx_reg[2:0], 3'b000} +: 8] : fcv_pkg::RB_PAST_END;
      rbIdx_next = (rbIdx_reg < fcv_pkg::RB_BYTES) ? rbIdx_reg + 4'h1 : rbIdx_reg;
    end else begin
      bitCnt_next = bitSum[2:0];
      outShift_next = quadLink ? {outShift_reg[3:0], 4'h0} : {outShift_reg[6:0], 1'b0};
    end
    dqOe_next = rdAct_next ? (quadLink ? 4'hf : 4'h2) : 4'h0;
    dqOut_next = quadLink ? outShift_next[7:4] : {2'b00, outShift_next[7], 1'b0};
  end

  // Link registers, cleared while select is high
  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      inShift_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      opSeen_reg <= 1'b0;
      rdAct_reg <= 1'b0;
      rbIdx_reg <= 4'h0;
      outShift_reg <= 8'h00;
      byteTgl_reg <= 1'b0;
      byteHold_reg <= 8'h00;
      dqOut_reg <= 4'h0;
      dqOe_reg <= 4'h0;
    end else begin
      inShift_reg <= inShift_next;
      bitCnt_reg <= bitCnt_next;
      opSeen_reg <= opSeen_next;
      rdAct_reg <= rdAct_next;
      rbIdx_reg <= rbIdx_next;
      outShift_reg <= outShift_next;
      byteTgl_reg <= byteTgl_next;
      byteHold_reg <= byteHold_next;
      dqOut_reg <= dqOut_next;
      dqOe_reg <= dqOe_next;
    end
  end

  assign dqOut = dqOut_reg;
  assign dqOe = dqOe_reg;

  // ==========================================================
  // Crossing into the system clock
  logic csS1, csS2, csS3, tglS1, tglS2, tglS3;
  logic byteEv, frameEnd;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      csS3 <= 1'b1;
      tglS1 <= 1'b0;
      tglS2 <= 1'b0;
      tglS3 <= 1'b0;
    end else begin
      csS1 <= csN;
      csS2 <= csS1;
      csS3 <= csS2;
      tglS1 <= byteTgl_reg;
      tglS2 <= tglS1;
      tglS3 <= tglS2;
    end
  end

  // Byte held stable in the link domain while its toggle settles
  assign byteEv = (tglS2 ^ tglS3) && !csS2;
  assign frameEnd = csS2 && !csS3;

  // ==========================================================
  // Frame decode and state gating
  logic [4:0] byteIdx_reg, byteIdx_next;
  logic [7:0] opcode_reg, opcode_next, sub_reg, sub_next, opt_reg, opt_next;
  logic [63:0] expCrc_reg, expCrc_next;
  logic [31:0] startAddr_reg, startAddr_next, stopAddr_reg, stopAddr_next;
  fcv_pkg::fcv_dev_state_t devState_reg, devState_next;
  fcv_pkg::fcv_pe_kind_t peKind_reg, peKind_next;
  fcv_pkg::fcv_cmd_class_t cmdClass_reg, cmdClass_next, cls;
  logic quadMode_next, rstArm_reg, rstArm_next;
  logic cmdAccept_reg, cmdAccept_next, cmdReject_reg, cmdReject_next;
  logic crcStart_reg, crcStart_next, clrFlag_reg, clrFlag_next;
  logic swReset_reg, swReset_next, allowed;

  // Frame decode next state
  always_comb begin
    byteIdx_next = byteIdx_reg;
    opcode_next = opcode_reg;
    sub_next = sub_reg;
    opt_next = opt_reg;
    expCrc_next = expCrc_reg;
    startAddr_next = startAddr_reg;
    stopAddr_next = stopAddr_reg;
    devState_next = devState_reg;
    peKind_next = peKind_reg;
    quadMode_next = quadMode_reg;
    rstArm_next = rstArm_reg;
    cmdClass_next = cmdClass_reg;
    cmdAccept_next = 1'b0;
    cmdReject_next = 1'b0;
    crcStart_next = 1'b0;
    clrFlag_next = 1'b0;
    swReset_next = 1'b0;
    cls = fcv_pkg::CL_NONE;
    allowed = 1'b0;
    // Running operation finished
    if (opDone && devState_reg == fcv_pkg::ST_PROG_ERASE) begin
      devState_next = fcv_pkg::ST_STANDBY;
    end
    // Capture bytes, multi-byte fields low byte first
    if (byteEv) begin
      if (byteIdx_reg == fcv_pkg::IDX_OPCODE) begin
        opcode_next = byteHold_reg;
        if (byteHold_reg == fcv_pkg::OP_QUAD_ENTER) quadMode_next = 1'b1;
        if (byteHold_reg == fcv_pkg::OP_QUAD_EXIT) quadMode_next = 1'b0;
      end else if (byteIdx_reg == fcv_pkg::IDX_SUB) begin
        sub_next = byteHold_reg;
      end else if (byteIdx_reg == fcv_pkg::IDX_OPTION) begin
        opt_next = byteHold_reg;
      end else if (byteIdx_reg < fcv_pkg::IDX_START_FIRST) begin
        expCrc_next = {byteHold_reg, expCrc_reg[63:8]};
      end else if (byteIdx_reg < fcv_pkg::IDX_STOP_FIRST) begin
        startAddr_next = {byteHold_reg, startAddr_reg[31:8]};
      end else if (byteIdx_reg < fcv_pkg::LEN_RANGE) begin
        stopAddr_next = {byteHold_reg, stopAddr_reg[31:8]};
      end
      if (byteIdx_reg != fcv_pkg::IDX_MAX) byteIdx_next = byteIdx_reg + 5'h01;
    end
    // Classify the finished frame
    if (byteIdx_reg != 5'h00) begin
      if (opcode_reg == fcv_pkg::OP_IFACE) begin
        if (sub_reg == fcv_pkg::SUB_CRC &&
            ((opt_reg == fcv_pkg::OPT_WHOLE && byteIdx_reg == fcv_pkg::LEN_WHOLE) ||
             (opt_reg == fcv_pkg::OPT_RANGE && byteIdx_reg == fcv_pkg::LEN_RANGE)))
          cls = fcv_pkg::CL_CRC;
        else
          cls = fcv_pkg::CL_OTHER;
      end else if (opcode_reg == OP_READ) cls = fcv_pkg::CL_READ;
      else if (opcode_reg == OP_RDSR || opcode_reg == OP_RDFSR ||
               opcode_reg == fcv_pkg::OP_RB_READ) cls = fcv_pkg::CL_STATUS;
      else if (opcode_reg == OP_PROG) cls = fcv_pkg::CL_PROG;
      else if (opcode_reg == OP_SECT_ERASE) cls = fcv_pkg::CL_ERASE;
      else if (opcode_reg == OP_SUB_ERASE) cls = fcv_pkg::CL_SUB_ERASE;
      else if (opcode_reg == OP_WRSR || opcode_reg == OP_WRNVCR ||
               opcode_reg == OP_OTP_PROG || opcode_reg == OP_DIE_ERASE)
        cls = fcv_pkg::CL_STANDBY_WR;
      else if (opcode_reg == OP_WRVCR || opcode_reg == OP_WREVCR ||
               opcode_reg == OP_WREN || opcode_reg == OP_WRDI ||
               opcode_reg == OP_CLRFS || opcode_reg == OP_WRLOCK)
        cls = fcv_pkg::CL_VOLATILE_WR;
      else if (opcode_reg == OP_SUSPEND) cls = fcv_pkg::CL_SUSPEND;
      else if (opcode_reg == OP_RESUME) cls = fcv_pkg::CL_RESUME;
      else if (opcode_reg == fcv_pkg::OP_QUAD_ENTER ||
               opcode_reg == fcv_pkg::OP_QUAD_EXIT) cls = fcv_pkg::CL_QUAD;
      else if (opcode_reg == OP_RST_EN || opcode_reg == OP_RST_MEM) cls = fcv_pkg::CL_RESET;
      else cls = fcv_pkg::CL_OTHER;
    end
    // Permission per device state
    unique case (cls)
      fcv_pkg::CL_READ: allowed = devState_reg != fcv_pkg::ST_PROG_ERASE;
      fcv_pkg::CL_PROG: allowed = devState_reg == fcv_pkg::ST_STANDBY ||
        (devState_reg == fcv_pkg::ST_ERASE_SUSP && !suspSectorHit);
      fcv_pkg::CL_ERASE, fcv_pkg::CL_SUB_ERASE: allowed =
        devState_reg == fcv_pkg::ST_STANDBY;
      fcv_pkg::CL_STANDBY_WR: allowed = devState_reg == fcv_pkg::ST_STANDBY;
      fcv_pkg::CL_VOLATILE_WR: allowed = devState_reg != fcv_pkg::ST_PROG_ERASE;
      fcv_pkg::CL_SUSPEND: allowed = devState_reg == fcv_pkg::ST_PROG_ERASE;
      fcv_pkg::CL_RESUME: allowed = devState_reg == fcv_pkg::ST_SUB_PROG_SUSP ||
        devState_reg == fcv_pkg::ST_ERASE_SUSP;
      fcv_pkg::CL_CRC: allowed = devState_reg == fcv_pkg::ST_STANDBY && !crcBusy_reg;
      fcv_pkg::CL_NONE: allowed = 1'b0;
      default: allowed = 1'b1;
    endcase
    // Act on the frame when select rises
    if (frameEnd) begin
      byteIdx_next = 5'h00;
      if (cls != fcv_pkg::CL_NONE) begin
        cmdClass_next = cls;
        cmdAccept_next = allowed;
        cmdReject_next = !allowed;
        rstArm_next = allowed && opcode_reg == OP_RST_EN;
      end
      if (allowed) begin
        unique case (cls)
          fcv_pkg::CL_PROG, fcv_pkg::CL_ERASE, fcv_pkg::CL_SUB_ERASE: begin
            devState_next = fcv_pkg::ST_PROG_ERASE;
            peKind_next = (cls == fcv_pkg::CL_PROG) ? fcv_pkg::PK_PROG :
              (cls == fcv_pkg::CL_ERASE) ? fcv_pkg::PK_ERASE : fcv_pkg::PK_SUB_ERASE;
          end
          fcv_pkg::CL_SUSPEND: devState_next = (peKind_reg == fcv_pkg::PK_ERASE) ?
            fcv_pkg::ST_ERASE_SUSP : fcv_pkg::ST_SUB_PROG_SUSP;
          fcv_pkg::CL_RESUME: devState_next = fcv_pkg::ST_PROG_ERASE;
          fcv_pkg::CL_VOLATILE_WR: clrFlag_next = opcode_reg == OP_CLRFS;
          fcv_pkg::CL_CRC: crcStart_next = 1'b1;
          fcv_pkg::CL_RESET: begin
            if (opcode_reg == OP_RST_MEM && rstArm_reg) begin
              swReset_next = 1'b1;
              devState_next = fcv_pkg::ST_STANDBY;
              quadMode_next = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Frame decode registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byteIdx_reg <= 5'h00;
      opcode_reg <= 8'h00;
      sub_reg <= 8'h00;
      opt_reg <= 8'h00;
      expCrc_reg <= 64'h0;
      startAddr_reg <= 32'h0;
      stopAddr_reg <= 32'h0;
      devState_reg <= fcv_pkg::ST_STANDBY;
      peKind_reg <= fcv_pkg::PK_PROG;
      cmdClass_reg <= fcv_pkg::CL_NONE;
      quadMode_reg <= 1'b0;
      rstArm_reg <= 1'b0;
      cmdAccept_reg <= 1'b0;
      cmdReject_reg <= 1'b0;
      crcStart_reg <= 1'b0;
      clrFlag_reg <= 1'b0;
      swReset_reg <= 1'b0;
    end else begin
      byteIdx_reg <= byteIdx_next;
      opcode_reg <= opcode_next;
      sub_reg <= sub_next;
      opt_reg <= opt_next;
      expCrc_reg <= expCrc_next;
      startAddr_reg <= startAddr_next;
      stopAddr_reg <= stopAddr_next;
      devState_reg <= devState_next;
      peKind_reg <= peKind_next;
      cmdClass_reg <= cmdClass_next;
      quadMode_reg <= quadMode_next;
      rstArm_reg <= rstArm_next;
      cmdAccept_reg <= cmdAccept_next;
      cmdReject_reg <= cmdReject_next;
      crcStart_reg <= crcStart_next;
      clrFlag_reg <= clrFlag_next;
      swReset_reg <= swReset_next;
    end
  end

  // ==========================================================
  // CRC engine
  fcv_pkg::fcv_crc_state_t crcState_reg, crcState_next;
  logic [63:0] crc_reg, crc_next;
  logic [31:0] memAddr_reg, memAddr_next, lastAddr_reg, lastAddr_next;
  logic memReq_reg, memReq_next, crcBusy_next;
  logic crcFail_reg, crcFail_next;

  // Engine next state
  always_comb begin
    crcState_next = crcState_reg;
    crc_next = crc_reg;
    memAddr_next = memAddr_reg;
    lastAddr_next = lastAddr_reg;
    memReq_next = memReq_reg;
    rbWord_next = rbWord_reg;
    crcFail_next = crcFail_reg;
    if (clrFlag_reg) crcFail_next = 1'b0;
    unique case (crcState_reg)
      fcv_pkg::CS_IDLE: begin
        if (crcStart_reg) begin
          rbWord_next = fcv_pkg::RB_RESET;
          crc_next = fcv_pkg::CRC_INIT;
          memAddr_next = (opt_reg == fcv_pkg::OPT_RANGE) ? startAddr_reg : 32'h0;
          lastAddr_next = (opt_reg == fcv_pkg::OPT_RANGE) ? stopAddr_reg : ARRAY_LAST;
          memReq_next = 1'b1;
          crcState_next = fcv_pkg::CS_FETCH;
        end
      end
      fcv_pkg::CS_FETCH: begin
        if (memValid) begin
          crc_next = crcByte(crc_reg, memData);
          if (memAddr_reg == lastAddr_reg) begin
            memReq_next = 1'b0;
            crcState_next = fcv_pkg::CS_CHECK;
          end else begin
            memAddr_next = memAddr_reg + 32'h1;
          end
        end
      end
      fcv_pkg::CS_CHECK: begin
        // Word held still while a frame is open
        if (csS2) begin
          crcFail_next = crc_reg != expCrc_reg;
          if (crc_reg != expCrc_reg) rbWord_next = crc_reg;
          crcState_next = fcv_pkg::CS_IDLE;
        end
      end
      default: crcState_next = fcv_pkg::CS_IDLE;
    endcase
    if (swReset_reg) begin
      rbWord_next = fcv_pkg::RB_RESET;
      crcFail_next = 1'b0;
      memReq_next = 1'b0;
      crcState_next = fcv_pkg::CS_IDLE;
    end
    crcBusy_next = crcState_next != fcv_pkg::CS_IDLE;
  end

  // Engine registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      crcState_reg <= fcv_pkg::CS_IDLE;
      crc_reg <= fcv_pkg::CRC_INIT;
      memAddr_reg <= 32'h0;
      lastAddr_reg <= 32'h0;
      memReq_reg <= 1'b0;
      rbWord_reg <= fcv_pkg::RB_RESET;
      crcFail_reg <= 1'b0;
      crcBusy_reg <= 1'b0;
    end else begin
      crcState_reg <= crcState_next;
      crc_reg <= crc_next;
      memAddr_reg <= memAddr_next;
      lastAddr_reg <= lastAddr_next;
      memReq_reg <= memReq_next;
      rbWord_reg <= rbWord_next;
      crcFail_reg <= crcFail_next;
      crcBusy_reg <= crcBusy_next;
    end
  end

  // Outputs
  assign memReq = memReq_reg;
  assign memAddr = memAddr_reg;
  assign cmdAccept = cmdAccept_reg;
  assign cmdReject = cmdReject_reg;
  assign cmdClass = cmdClass_reg;
  assign devState = devState_reg;
  assign quadMode = quadMode_reg;
  assign crcBusy = crcBusy_reg;
  assign crcFailFlag = crcFail_reg;

endmodule : fcv_cmd_gate

/* logic/fcv_pkg.sv */
package fcv_pkg;

  // ==========================================================
  // Command bytes
  localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hf5;
  localparam logic [7:0] OP_RB_READ = 8'h96;
  localparam logic [7:0] OP_IFACE = 8'h9b;
  localparam logic [7:0] SUB_CRC = 8'h27;
  localparam logic [7:0] OPT_WHOLE = 8'hff;
  localparam logic [7:0] OPT_RANGE = 8'hfe;

  // ==========================================================
  // Frame layout, byte indices counted from the opcode
  localparam logic [4:0] IDX_OPCODE = 5'h00;
  localparam logic [4:0] IDX_SUB = 5'h01;
  localparam logic [4:0] IDX_OPTION = 5'h02;
  localparam logic [4:0] IDX_EXP_FIRST = 5'h03;
  localparam logic [4:0] IDX_START_FIRST = 5'h0b;
  localparam logic [4:0] IDX_STOP_FIRST = 5'h0f;
  localparam logic [4:0] LEN_WHOLE = 5'h0b;
  localparam logic [4:0] LEN_RANGE = 5'h13;
  localparam logic [4:0] IDX_MAX = 5'h1f;

  // ==========================================================
  // CRC engine and read-back word
  localparam logic [63:0] CRC_POLY = 64'h42f0e1eba9ea3693;
  localparam logic [63:0] CRC_INIT = 64'h0000000000000000;
  localparam logic [63:0] RB_RESET = 64'h0000000000000000;
  localparam logic [3:0] RB_BYTES = 4'h8;
  localparam logic [7:0] RB_PAST_END = 8'h00;

  // ==========================================================
  // Device states
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_PROG_ERASE = 2'b01,
    ST_SUB_PROG_SUSP = 2'b10,
    ST_ERASE_SUSP = 2'b11
  } fcv_dev_state_t;

  // Kind of the running array operation
  typedef enum logic [1:0] {
    PK_PROG = 2'b00,
    PK_ERASE = 2'b01,
    PK_SUB_ERASE = 2'b10
  } fcv_pe_kind_t;

  // Command classes reported at frame end
  typedef enum logic [3:0] {
    CL_NONE = 4'h0,
    CL_READ = 4'h1,
    CL_STATUS = 4'h2,
    CL_PROG = 4'h3,
    CL_ERASE = 4'h4,
    CL_SUB_ERASE = 4'h5,
    CL_STANDBY_WR = 4'h6,
    CL_VOLATILE_WR = 4'h7,
    CL_SUSPEND = 4'h8,
    CL_RESUME = 4'h9,
    CL_CRC = 4'ha,
    CL_QUAD = 4'hb,
    CL_RESET = 4'hc,
    CL_OTHER = 4'hd
  } fcv_cmd_class_t;

  // CRC engine states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_FETCH = 2'b01,
    CS_CHECK = 2'b10
  } fcv_crc_state_t;

endpackage : fcv_pkg

/* verif/fcv_monitor.sv */
// ==========================================================
// Port checker
module fcv_monitor (
  // Clock, reset, link select and output enables
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic [3:0] dqOe,
  // Array port
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic memValid,
  // Status
  input wire logic cmdAccept,
  input wire logic cmdReject,
  input wire logic [3:0] cmdClass,
  input wire logic [1:0] devState,
  input wire logic crcBusy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_one_verdict: assert property (!(cmdAccept && cmdReject)) else $error("two verdicts");
  a_reject_keeps_state: assert property (cmdReject |-> $stable(devState))
    else $error("refused frame moved state");
  a_status_never_refused: assert property (cmdReject |-> cmdClass != fcv_pkg::CL_STATUS)
    else $error("status read refused");
  a_read_gate: assert property (cmdAccept && cmdClass == fcv_pkg::CL_READ |->
    $past(devState) != fcv_pkg::ST_PROG_ERASE) else $error("read taken while busy");
  a_erase_gate: assert property (cmdAccept && cmdClass == fcv_pkg::CL_SUB_ERASE |->
    $past(devState) == fcv_pkg::ST_STANDBY) else $error("erase outside standby");
  a_suspend_gate: assert property (cmdAccept && cmdClass == fcv_pkg::CL_SUSPEND |->
    $past(devState) == fcv_pkg::ST_PROG_ERASE) else $error("suspend while idle");
  a_crc_start: assert property (cmdAccept && cmdClass == fcv_pkg::CL_CRC |=> crcBusy)
    else $error("crc did not start");
  a_crc_standby: assert property ($rose(crcBusy) |-> devState == fcv_pkg::ST_STANDBY)
    else $error("crc outside standby");
  a_fetch_hold: assert property (memReq && !memValid |=> memReq && $stable(memAddr))
    else $error("fetch dropped");
  a_addr_step: assert property (memReq && memValid |=> !memReq ||
    memAddr == $past(memAddr) + 32'h1) else $error("address skipped");
  a_idle_lines: assert property (csN [*3] |-> dqOe == 4'h0) else $error("driving when idle");
endmodule : fcv_monitor

bind fcv_cmd_gate fcv_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n), .csN(csN),
  .dqOe(dqOe), .memReq(memReq), .memAddr(memAddr), .memValid(memValid),
  .cmdAccept(cmdAccept), .cmdReject(cmdReject), .cmdClass(cmdClass),
  .devState(devState), .crcBusy(crcBusy));

/* verif/fcv_host_model.sv */
// ==========================================================
// Host serial controller
module fcv_host_model (
  // Link outputs
  output logic linkClk,
  output logic csN,
  output logic [3:0] dqIn,
  // Link input
  input wire logic [3:0] dqOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    linkClk = 1'b0;
    csN = 1'b1;
    dqIn = 4'h0;
  end
  // One frame, bytes MSB first, two clocks before select falls
  task automatic frame(input logic [151:0] b, input int n, input bit q, input int nrd,
      output logic [71:0] rd);
    int w;
    w = q ? 4 : 1;
    rd = '0;
    // Two edges while deselected carry the mode into the link domain
    repeat (2) begin
      #32 linkClk = 1'b1;
      #32 linkClk = 1'b0;
    end
    csN = 1'b0;
    #20;
    for (int i = 0; i < (8 * (n + nrd) - (nrd > 0 ? 1 : 0)) / w; i++) begin
      dqIn = (i * w < 8 * n) ? 4'(b >> (8 * n - w * (i + 1))) & (q ? 4'hf : 4'h1) : 4'h0;
      #16 linkClk = 1'b1;
      #16 if (i * w >= 8 * n - 1) rd = {rd[70:0], dqOut[1]};
      #16 linkClk = 1'b0;
      #16;
    end
    #64 csN = 1'b1; // Select rise confirms the sequence
    dqIn = ~dqIn; // Released lines do not keep the last value
  endtask : frame
endmodule : fcv_host_model

/* verif/tb.sv */
// ==========================================================
// Testbench top
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_n = 1'b0, memValid = 1'b0, opDone = 1'b0, suspSectorHit = 1'b0;
  logic [7:0] memData = 8'h00;
  logic linkClk, csN, memReq, cmdAccept, cmdReject, quadMode, crcBusy, crcFailFlag, acc, rej;
  logic [3:0] dqIn, dqOut, dqOe, cmdClass;
  logic [31:0] memAddr;
  logic [1:0] devState;
  logic [71:0] rd;
  int mismatches = 0, compares = 0;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); end end
  always #4 sys_clk = ~sys_clk;
  // Array answers every other cycle
  always @(negedge sys_clk) begin
    memValid <= memReq & ~memValid;
    memData <= {memAddr[3:0], ~memAddr[3:0]};
  end
  fcv_host_model i_host (.linkClk(linkClk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut));
  fcv_cmd_gate #(.ARRAY_LAST(32'h0000000f)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .linkClk(linkClk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .memReq(memReq),
    .memAddr(memAddr), .memValid(memValid), .memData(memData), .opDone(opDone),
    .suspSectorHit(suspSectorHit), .cmdAccept(cmdAccept), .cmdReject(cmdReject),
    .cmdClass(cmdClass), .devState(devState), .quadMode(quadMode), .crcBusy(crcBusy),
    .crcFailFlag(crcFailFlag));
  task finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  function automatic logic [63:0] bsw(input logic [63:0] x);
    bsw = {<<8{x}};
  endfunction : bsw
  // Reference CRC, bits low first
  function automatic logic [63:0] crc(input int lo, input int hi);
    logic [63:0] c;
    logic [7:0] d;
    c = fcv_pkg::CRC_INIT;
    for (int a = lo; a <= hi; a++) begin
      d = {a[3:0], ~a[3:0]};
      for (int k = 0; k < 8; k++) c = {c[62:0], 1'b0} ^ ((c[63] ^ d[k]) ? fcv_pkg::CRC_POLY : '0);
    end
    return c;
  endfunction : crc
  task automatic go(input logic [151:0] b, input int n, input bit q = 0, input int nrd = 0);
    i_host.frame(b, n, q, nrd, rd);
    acc = 1'b0;
    rej = 1'b0;
    for (int i = 0; i < 20 && !(acc | rej); i++) begin
      @(posedge sys_clk);
      #1 acc = cmdAccept;
      rej = cmdReject;
    end
    if (!(acc | rej)) begin
      mismatches++;
      finish_test;
    end
  endtask : go
  task automatic t_crc(input bit rng, input int lo, input int hi, input bit good);
    logic [63:0] c, e, a, z;
    c = crc(lo, hi);
    e = bsw(c ^ {63'h0, !good});
    a = bsw({32'h0, 32'(lo)});
    z = bsw({32'h0, 32'(hi)});
    if (rng) go({fcv_pkg::OP_IFACE, fcv_pkg::SUB_CRC, fcv_pkg::OPT_RANGE, e, a[63:32], z[63:32]}, 19);
    else go({fcv_pkg::OP_IFACE, fcv_pkg::SUB_CRC, fcv_pkg::OPT_WHOLE, e}, 11);
    `CHK(cmdClass, fcv_pkg::CL_CRC)
    for (int i = 0; i < 300 && (i < 3 || crcBusy); i++) @(negedge sys_clk);
    if (crcBusy) begin
      mismatches++;
      finish_test;
    end
    `CHK(crcFailFlag, !good)
    go(fcv_pkg::OP_RB_READ, 1, 0, 9);
    `CHK(rd, {good ? 64'h0 : bsw(c), 8'h00})
  endtask : t_crc
  task automatic step(input logic [151:0] b, input int n, input bit ea, input logic [1:0] es);
    go(b, n);
    repeat (2) @(negedge sys_clk);
    `CHK({acc, devState}, {ea, es})
  endtask : step
  // Main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    go(fcv_pkg::OP_RB_READ, 1, 0, 9);
    `CHK({rd, crcFailFlag, acc}, {72'h0, 1'b0, 1'b1})
    t_crc(0, 0, 15, 0);
    t_crc(0, 0, 15, 1);
    t_crc(1, 4, 7, 0);
    step({i_dut.OP_SUB_ERASE, 32'h0}, 5, 1, fcv_pkg::ST_PROG_ERASE);
    step({i_dut.OP_READ, 32'h0}, 5, 0, fcv_pkg::ST_PROG_ERASE);
    step(i_dut.OP_RDFSR, 1, 1, fcv_pkg::ST_PROG_ERASE);
    step({i_dut.OP_PROG, 32'h20, 8'haa}, 6, 0, fcv_pkg::ST_PROG_ERASE);
    step(i_dut.OP_WREN, 1, 0, fcv_pkg::ST_PROG_ERASE);
    step(i_dut.OP_SUSPEND, 1, 1, fcv_pkg::ST_SUB_PROG_SUSP);
    step(i_dut.OP_SUSPEND, 1, 0, fcv_pkg::ST_SUB_PROG_SUSP);
    step({i_dut.OP_READ, 32'h0}, 5, 1, fcv_pkg::ST_SUB_PROG_SUSP);
    step({i_dut.OP_PROG, 32'h20, 8'haa}, 6, 0, fcv_pkg::ST_SUB_PROG_SUSP);
    step(i_dut.OP_WREN, 1, 1, fcv_pkg::ST_SUB_PROG_SUSP);
    step({i_dut.OP_WRSR, 8'h00}, 2, 0, fcv_pkg::ST_SUB_PROG_SUSP);
    step(i_dut.OP_RESUME, 1, 1, fcv_pkg::ST_PROG_ERASE);
    @(negedge sys_clk) opDone = 1'b1;
    @(negedge sys_clk) opDone = 1'b0;
    `CHK(devState, fcv_pkg::ST_STANDBY)
    go(fcv_pkg::OP_QUAD_ENTER, 1);
    `CHK(quadMode, 1'b1)
    go(fcv_pkg::OP_QUAD_EXIT, 1, 1);
    `CHK(quadMode, 1'b0)
    go(i_dut.OP_RST_EN, 1);
    step(i_dut.OP_RST_MEM, 1, 1, fcv_pkg::ST_STANDBY);
    go(fcv_pkg::OP_RB_READ, 1, 0, 9);
    `CHK(rd, 72'h0)
    finish_test;
  end
endmodule : tb
